// ===== dv/crs_core_regs_bench.sv
module crs_core_regs_bench import crs_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic          clk_sys, rst_n, sfrWrEn, sfrRdEn, mainWrEn, auxWrEn, ptrLoad, ptrInc;
	logic          pushReq, popReq, addrReqValid, instrStart, sfrRdHit_q, stackRamWr_q;
	logic          stackRamRd_q, effValid_q, instrBusy_q, instrDone_q, hit;
	logic [7:0]    sfrAddr, sfrWrData, mainWrData, auxWrData, pushData, rd, eAcc, eSw, eSp;
	logic [7:0]    sfrRdData_q, stackRamAddr_q, stackRamData_q, regAddr_q, popData_q;
	logic [7:0]    mainOperand_q, auxOperand_q, statusWord_q, stackPointer_q;
	logic [7:0]    vals [6];
	logic [7:0]    addrs [7];
	logic [7:0]    rsts [7];
	logic [15:0]   ptrLoadData, effAddr_q, dataPointer_q, eDp;
	logic [2:0]    instrCycles;
	crs_flag_upd_t flagUpd;
	crs_addr_req_t addrReq, r;
	crs_space_t    effSpace_q;
	int            fail_count, n_compared, i, j, n;

	crs_core_regs crs_core_regs_inst (
		.clk_sys, .rst_n, .sfrWrEn, .sfrRdEn, .sfrAddr, .sfrWrData, .sfrRdData_q, .sfrRdHit_q,
		.mainWrEn, .mainWrData, .auxWrEn, .auxWrData, .flagUpd, .ptrLoad, .ptrLoadData, .ptrInc,
		.pushReq, .pushData, .popReq, .stackRamAddr_q, .stackRamWr_q, .stackRamRd_q,
		.stackRamData_q, .addrReqValid, .addrReq, .effValid_q, .effAddr_q, .effSpace_q,
		.regAddr_q, .instrStart, .instrCycles, .instrBusy_q, .instrDone_q, .mainOperand_q,
		.auxOperand_q, .statusWord_q, .stackPointer_q, .dataPointer_q
	);
	crs_ram_model crs_ram_model_inst (
		.clk_sys, .stackRamAddr_q, .stackRamWr_q, .stackRamRd_q, .stackRamData_q, .popData_q
	);

	initial begin
		clk_sys = 1'h0;
		forever #2 clk_sys = ~clk_sys;
	end

	task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// one edge takes the request, then every strobe drops so none repeats
	task automatic fire();
		@(posedge clk_sys);
		{sfrWrEn, sfrRdEn, mainWrEn, auxWrEn, ptrLoad, ptrInc} <= 6'h00;
		{pushReq, popReq, addrReqValid, instrStart} <= 4'h0;
		flagUpd <= 6'h00;
		#1;
	endtask : fire

	task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		sfrWrEn <= w;
		sfrRdEn <= !w;
		sfrAddr <= a;
		sfrWrData <= d;
		fire();
		rd = sfrRdData_q;
		hit = sfrRdHit_q;
	endtask : sfr

	// where each addressing mode should land, from the tracked register state
	function automatic logic [20:0] exp_eff(input crs_addr_req_t q);
		logic [15:0] acc;
		acc = {8'h00, eAcc};
		case (q.mode)
			MODE_DIRECT:    return {q.addrField[7] ? SPACE_SFR : SPACE_DATA, 8'h00, q.addrField};
			MODE_IND_RI:    return {SPACE_DATA, 8'h00, q.riData};
			MODE_IND_RI_X:  return {SPACE_XRAM, 8'h00, q.riData};
			MODE_IND_SP:    return {SPACE_DATA, 8'h00, eSp};
			MODE_IND_DATA_POINTER:  return {SPACE_XRAM, eDp};
			MODE_REGISTER:  return {SPACE_DATA, 11'h000, eSw[4:3], q.regSel};
			MODE_IDX_PC:    return {SPACE_CODE, q.pc + acc};
			MODE_IMMEDIATE: return {SPACE_CODE, q.pc + 16'h0001};
			default:        return {SPACE_CODE, eDp + acc};
		endcase
	endfunction : exp_eff

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up

	// the tests need some 220 clocks; 50,000 means a hang
	initial begin
		#200000;
		fail_count++;
		wrap_up();
	end

	initial begin
		rst_n = 1'h0;
		{sfrWrEn, sfrRdEn, mainWrEn, auxWrEn, ptrLoad, ptrInc} = 6'h00;
		{pushReq, popReq, addrReqValid, instrStart} = 4'h0;
		{sfrAddr, sfrWrData, mainWrData, auxWrData, pushData} = 40'h00_0000_0000;
		{ptrLoadData, instrCycles, flagUpd, addrReq} = 70'h0;
		fail_count = 0;
		n_compared = 0;
		addrs = '{CRS_ADDR_STACK_POINTER, CRS_ADDR_POINTER_LOW, CRS_ADDR_POINTER_HIGH,
			CRS_ADDR_STATUS_WORD, CRS_ADDR_MAIN_OPERAND, CRS_ADDR_AUX_OPERAND, 8'h80};
		rsts = '{CRS_RST_STACK_POINTER, CRS_RST_POINTER_LOW, CRS_RST_POINTER_HIGH,
			CRS_RST_STATUS_WORD, CRS_RST_MAIN_OPERAND, CRS_RST_AUX_OPERAND, 8'h00};
		n = $urandom(32'h46ed);
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'h1;
		// reset values, then an unmapped address that must miss
		for (i = 0; i < 7; i++) begin
			sfr(1'h0, addrs[i], 8'h00);
			chk("reset read", {hit, rd}, {i < 6, rsts[i]});
		end
		// random write and read back; the status word keeps its own parity
		for (i = 0; i < 6; i++) begin
			n = $urandom;
			vals[i] = n[7:0];
			sfr(1'h1, addrs[i], vals[i]);
			sfr(1'h0, addrs[i], 8'h00);
			chk("readback", rd, i == 3 ? {n[7:1], 1'h0} : n[7:0]);
		end
		{eSp, eDp, eSw, eAcc} = {vals[0], vals[2], vals[1], vals[3], vals[4]};
		chk("pointer pair", dataPointer_q, eDp);
		// results with random flag updates; parity follows, user flags stay
		for (i = 0; i < 8; i++) begin
			n = $urandom;
			if (i == 0)
				n[7:0] = 8'h80;
			@(posedge clk_sys);
			{mainWrEn, auxWrEn} <= 2'h3;
			{auxWrData, mainWrData} <= n[15:0];
			flagUpd <= n[21:16];
			fire();
			eAcc = n[7:0];
			if (n[21]) eSw[7] = n[20];
			if (n[19]) eSw[6] = n[18];
			if (n[17]) eSw[2] = n[16];
			chk("status word", statusWord_q, {eSw[7:1], ^eAcc});
			chk("aux operand", auxOperand_q, n[15:8]);
		end
		// every addressing mode in each of the four banks
		for (i = 0; i < 40; i++) begin
			if (i % 10 == 0) begin
				eSw[4:3] = 2'(i / 10);
				sfr(1'h1, CRS_ADDR_STATUS_WORD, eSw);
			end
			r = 45'({$urandom, $urandom});
			r.mode = crs_mode_t'(10'h001 << (i % 10));
			if (i == 0) r.addrField = 8'h7f;
			if (i == 10) r.addrField = 8'h80;
			@(posedge clk_sys);
			addrReqValid <= 1'h1;
			addrReq <= r;
			fire();
			chk("operand", {effValid_q, effSpace_q, effAddr_q}, {1'h1, exp_eff(r)});
			chk("bank reg", regAddr_q, {3'h0, eSw[4:3], r.mode == MODE_REGISTER ? r.regSel
				: {2'h0, r.regSel[0]}});
		end
		// three pushes across the top of ram, then three pops back
		sfr(1'h1, CRS_ADDR_STACK_POINTER, 8'hfe);
		for (i = 0; i < 6; i++) begin
			@(posedge clk_sys);
			if (i < 3) pushReq <= 1'h1;
			else popReq <= 1'h1;
			pushData <= vals[i % 3];
			fire();
			n = i < 3 ? 255 + i : 259 - i;
			chk("stack ptr", stackPointer_q, n[7:0]);
			@(posedge clk_sys);
			#1;
			if (i > 2) chk("pop data", popData_q, vals[5 - i]);
		end
		// increment must carry into the high byte
		@(posedge clk_sys);
		ptrLoad <= 1'h1;
		ptrLoadData <= 16'h00ff;
		fire();
		@(posedge clk_sys);
		ptrInc <= 1'h1;
		fire();
		sfr(1'h0, CRS_ADDR_POINTER_HIGH, 8'h00);
		chk("pointer high", {dataPointer_q, rd}, 24'h010001);
		// every instruction length from one to seven clocks
		for (i = 1; i < 8; i++) begin
			@(posedge clk_sys);
			instrStart <= 1'h1;
			instrCycles <= 3'(i);
			fire();
			// j counts edges after the start edge, so a one-clock instruction gives one
			for (j = 0; instrDone_q !== 1'h1 && j < 20; j++) begin
				@(posedge clk_sys);
				#1;
			end
			chk("instr length", j, i);
		end
		// a second reset mid-run restores the pointer to seven
		@(posedge clk_sys);
		rst_n <= 1'h0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'h1;
		#1;
		chk("second reset", {stackPointer_q, dataPointer_q}, 24'h070000);
		wrap_up();
	end
endmodule : crs_core_regs_bench

// ===== dv/crs_core_regs_monitor.sv
module crs_core_regs_monitor
	import crs_pkg::*;
(
	// clock and reset
	input wire logic          clk_sys,
	input wire logic          rst_n,
	// requests into the block
	input wire logic          sfrWrEn,
	input wire logic [7:0]    sfrAddr,
	input wire crs_flag_upd_t flagUpd,
	input wire logic          ptrLoad,
	input wire logic [15:0]   ptrLoadData,
	input wire logic          pushReq,
	input wire logic [7:0]    pushData,
	input wire logic          popReq,
	input wire logic          addrReqValid,
	input wire crs_addr_req_t addrReq,
	input wire logic          instrStart,
	// answers of the block
	input wire logic [7:0]    stackRamAddr_q,
	input wire logic          stackRamWr_q,
	input wire logic          stackRamRd_q,
	input wire logic [7:0]    stackRamData_q,
	input wire logic          effValid_q,
	input wire logic [15:0]   effAddr_q,
	input wire crs_space_t    effSpace_q,
	input wire logic          instrBusy_q,
	input wire logic          instrDone_q,
	input wire logic [7:0]    mainOperand_q,
	input wire logic [7:0]    statusWord_q,
	input wire logic [7:0]    stackPointer_q,
	input wire logic [15:0]   dataPointer_q
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// whole-signal copies, so $past never sees a part-select
	wire logic [1:0]  bankNow  = statusWord_q[4:3];
	wire logic [1:0]  userNow  = {statusWord_q[5], statusWord_q[1]};
	wire logic [2:0]  selNow   = addrReq.regSel;
	wire logic [7:0]  fieldNow = addrReq.addrField;
	wire logic [15:0] accWide  = {8'h00, mainOperand_q};
	wire logic        carryNow = flagUpd.carry;
	wire logic        idleNow  = !instrBusy_q && !instrDone_q;

	// store lands one above the old top, which becomes the new top
	sequence push_s;
		stackRamWr_q && stackRamAddr_q == stackPointer_q && stackRamData_q == $past(pushData)
			&& stackPointer_q == $past(stackPointer_q) + 8'h01;
	endsequence
	// read at the old top, then the pointer falls by one
	sequence pop_s;
		stackRamRd_q && stackRamAddr_q == $past(stackPointer_q)
			&& stackPointer_q == $past(stackPointer_q) - 8'h01;
	endsequence
	// busy on the first clock after the start, done one to seven clocks on
	sequence run_s;
		instrBusy_q ##[1:7] instrDone_q;
	endsequence

	parity_track_a: assert property (statusWord_q[0] == ^mainOperand_q)
		else $error("parity bit does not match operand");
	push_order_a: assert property (pushReq |=> push_s)
		else $error("push did not store above the old top");
	pop_order_a: assert property (popReq && !pushReq |=> pop_s)
		else $error("pop did not read the top before falling");
	bank_register_a: assert property (
		addrReqValid && addrReq.mode == MODE_REGISTER |=> effValid_q && effSpace_q == SPACE_DATA
			&& effAddr_q == {11'h000, $past(bankNow), $past(selNow)})
		else $error("register operand outside the selected bank");
	direct_space_a: assert property (
		addrReqValid && addrReq.mode == MODE_DIRECT |=> effAddr_q[7:0] == $past(fieldNow)
			&& effSpace_q == (effAddr_q[7] ? SPACE_SFR : SPACE_DATA))
		else $error("direct operand in wrong space");
	indexed_code_a: assert property (
		addrReqValid && (addrReq.mode == MODE_IDX_DATA_POINTER || addrReq.mode == MODE_JMP_IDX)
			|=> effSpace_q == SPACE_CODE
			&& effAddr_q == $past(dataPointer_q) + $past(accWide))
		else $error("indexed address is not pointer plus operand");
	instr_length_a: assert property (instrStart && idleNow |=> run_s)
		else $error("instruction did not finish in one to seven clocks");
	carry_bit_a: assert property (flagUpd.carryEn |=> statusWord_q[7] == $past(carryNow))
		else $error("carry bit not taken from the result");
	user_flags_a: assert property (
		!(sfrWrEn && sfrAddr == CRS_ADDR_STATUS_WORD) |=> $stable(userNow))
		else $error("user flag changed without a status write");
	pointer_load_a: assert property (ptrLoad |=> dataPointer_q == $past(ptrLoadData))
		else $error("data pointer load lost");
endmodule : crs_core_regs_monitor

bind crs_core_regs crs_core_regs_monitor crs_core_regs_monitor_inst (
	.clk_sys, .rst_n, .sfrWrEn, .sfrAddr, .flagUpd, .ptrLoad, .ptrLoadData, .pushReq,
	.pushData, .popReq, .addrReqValid, .addrReq, .instrStart, .stackRamAddr_q,
	.stackRamWr_q, .stackRamRd_q, .stackRamData_q, .effValid_q, .effAddr_q, .effSpace_q,
	.instrBusy_q, .instrDone_q, .mainOperand_q, .statusWord_q, .stackPointer_q,
	.dataPointer_q
);

// ===== dv/crs_ram_model.sv
module crs_ram_model (
	// clock
	input  wire logic       clk_sys,
	// stack request from the register set
	input  wire logic [7:0] stackRamAddr_q,
	input  wire logic       stackRamWr_q,
	input  wire logic       stackRamRd_q,
	input  wire logic [7:0] stackRamData_q,
	// byte answered for a pop
	output logic [7:0]      popData_q
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [256];

	initial popData_q = 8'h00;
	// answer one edge after a read; flips otherwise so stale data never matches
	always @(posedge clk_sys) begin
		if (stackRamWr_q)
			mem[stackRamAddr_q] <= stackRamData_q;
		popData_q <= stackRamRd_q ? mem[stackRamAddr_q] : ~popData_q;
	end
endmodule : crs_ram_model

// ===== rtl/crs_addr_unit.sv
module crs_addr_unit
	import crs_pkg::*;
(
	// request and current register state
	input  wire crs_addr_req_t req,
	input  wire logic [1:0]    bankSel,
	input  wire logic [7:0]    stackPtr,
	input  wire logic [15:0]   dataPtr,
	input  wire logic [7:0]    mainOperand,
	// resolved operand location
	output logic [15:0]        effAddr,
	output crs_space_t         effSpace,
	output logic [7:0]         regAddr
);

	logic [7:0] bankBase;

	// bank base: four banks of eight in the lowest bytes
	assign bankBase = {3'h0, bankSel, 3'h0};

	// register field picks one of eight in the current bank; Ri uses only bit 0
	always_comb begin
		regAddr = 8'h00;
		if (req.mode == MODE_REGISTER) begin
			regAddr = bankBase | {5'h00, req.regSel};
		end else begin
			regAddr = bankBase | {7'h00, req.regSel[0]};
		end
	end

	// effective address per mode
	always_comb begin
		effAddr  = 16'h0000;
		effSpace = SPACE_NONE;
		case (req.mode)
			MODE_DIRECT: begin
				effAddr  = {8'h00, req.addrField};
				effSpace = (req.addrField >= CRS_SFR_BOUNDARY) ? SPACE_SFR : SPACE_DATA;
			end
			MODE_IND_RI: begin
				effAddr  = {8'h00, req.riData};
				effSpace = SPACE_DATA;
			end
			MODE_IND_RI_X: begin
				effAddr  = {8'h00, req.riData};
				effSpace = SPACE_XRAM;
			end
			MODE_IND_SP: begin
				effAddr  = {8'h00, stackPtr};
				effSpace = SPACE_DATA;
			end
			MODE_IND_DATA_POINTER: begin
				effAddr  = dataPtr;
				effSpace = SPACE_XRAM;
			end
			MODE_REGISTER: begin
				effAddr  = {8'h00, regAddr};
				effSpace = SPACE_DATA;
			end
			MODE_IDX_DATA_POINTER: begin
				effAddr  = dataPtr + {8'h00, mainOperand};
				effSpace = SPACE_CODE;
			end
			MODE_IDX_PC: begin
				effAddr  = req.pc + {8'h00, mainOperand};
				effSpace = SPACE_CODE;
			end
			MODE_JMP_IDX: begin
				effAddr  = dataPtr + {8'h00, mainOperand};
				effSpace = SPACE_CODE;
			end
			MODE_IMMEDIATE: begin
				effAddr  = req.pc + 16'h0001;
				effSpace = SPACE_CODE;
			end
			default: begin
				effAddr  = 16'h0000;
				effSpace = SPACE_NONE;
			end
		endcase
	end

endmodule : crs_addr_unit

// ===== rtl/crs_core_regs.sv
// Operation
// - status word: carry 7, half carry 6, user0 5, bank 4:3, signed 2, user1 1, parity 0
// - two bank bits pick one of four banks; R0..R7 resolve into it
// - parity is one when main operand holds odd ones, tracks every change
// - carry flag also serves as the one-bit accumulator for bit operations
// - stack pointer marks top of stack, incremented before each push store
// - stack pointer resets to seven, timer state to idle, operand space to none, every other register here to zero
// - data pointer is high byte over low byte, used for xram and code
// - auxiliary operand register acts as a second accumulator
// - instructions take one to seven clocks, timed purely in clock cycles
// - direct mode uses an 8-bit field reaching only internal ram and sfrs
// - 8-bit indirect via R0, R1 or stack pointer; 16-bit only data pointer
// - register mode: 3-bit opcode field picks one of eight bank registers
// - indexed mode reads code only: data pointer or pc plus main operand
// - indexed jump target is base pointer plus main operand
// - immediate operand is fetched from code bytes following the opcode
// - status word lives at sfr 0xd0 on every page, resets to zero
// - user flags are plain read-write bits no result ever changes
// - four banks of eight occupy the lowest 32 bytes of internal ram
module crs_core_regs
	import crs_pkg::*;
(
	// clock and reset
	input  wire logic          clk_sys,
	input  wire logic          rst_n,
	// direct sfr access from the execution path
	input  wire logic          sfrWrEn,
	input  wire logic          sfrRdEn,
	input  wire logic [7:0]    sfrAddr,
	input  wire logic [7:0]    sfrWrData,
	output logic [7:0]         sfrRdData_q,
	output logic               sfrRdHit_q,
	// instruction results
	input  wire logic          mainWrEn,
	input  wire logic [7:0]    mainWrData,
	input  wire logic          auxWrEn,
	input  wire logic [7:0]    auxWrData,
	input  wire crs_flag_upd_t flagUpd,
	input  wire logic          ptrLoad,
	input  wire logic [15:0]   ptrLoadData,
	input  wire logic          ptrInc,
	// stack operations
	input  wire logic          pushReq,
	input  wire logic [7:0]    pushData,
	input  wire logic          popReq,
	output logic [7:0]         stackRamAddr_q,
	output logic               stackRamWr_q,
	output logic               stackRamRd_q,
	output logic [7:0]         stackRamData_q,
	// operand addressing
	input  wire logic          addrReqValid,
	input  wire crs_addr_req_t addrReq,
	output logic               effValid_q,
	output logic [15:0]        effAddr_q,
	output crs_space_t         effSpace_q,
	output logic [7:0]         regAddr_q,
	// instruction timing
	input  wire logic          instrStart,
	input  wire logic [2:0]    instrCycles,
	output logic               instrBusy_q,
	output logic               instrDone_q,
	// register state seen by the core
	output logic [7:0]         mainOperand_q,
	output logic [7:0]         auxOperand_q,
	output logic [7:0]         statusWord_q,
	output logic [7:0]         stackPointer_q,
	output logic [15:0]        dataPointer_q
);

	// architectural registers
	logic [7:0] mainOp_d, mainOp_r;
	logic [7:0] auxOp_d, auxOp_r;
	logic [7:0] status_d, status_r;
	logic [7:0] sp_d, sp_r;
	logic [7:0] ptrLow_d, ptrLow_r;
	logic [7:0] ptrHigh_d, ptrHigh_r;

	// stack ram request
	logic [7:0] stkAddr_d;
	logic       stkWr_d;
	logic       stkRd_d;
	logic [7:0] stkData_d;

	// sfr read port
	logic [7:0] rdData_d;
	logic       rdHit_d;

	// address unit results
	logic [15:0] calcAddr;
	crs_space_t  calcSpace;
	logic [7:0]  calcReg;

	// instruction timer
	crs_tmr_state_t tmrState_d, tmrState_q;
	logic [2:0]     tmrCount_d, tmrCount_q;
	logic           done_d;

	// main and auxiliary operand; an sfr write loses to a same-cycle result
	always_comb begin
		mainOp_d = mainOp_r;
		auxOp_d  = auxOp_r;
		if (sfrWrEn && sfrAddr == CRS_ADDR_MAIN_OPERAND) begin
			mainOp_d = sfrWrData;
		end
		if (mainWrEn) begin
			mainOp_d = mainWrData;
		end
		if (sfrWrEn && sfrAddr == CRS_ADDR_AUX_OPERAND) begin
			auxOp_d = sfrWrData;
		end
		if (auxWrEn) begin
			auxOp_d = auxWrData;
		end
	end

	// status word; parity is rebuilt from the next main operand so it never lags
	always_comb begin
		status_d = status_r;
		if (sfrWrEn && sfrAddr == CRS_ADDR_STATUS_WORD) begin
			status_d = sfrWrData;
		end
		if (flagUpd.carryEn) begin
			status_d[CRS_POS_CARRY] = flagUpd.carry;
		end
		if (flagUpd.halfCarryEn) begin
			status_d[CRS_POS_HALF_CARRY] = flagUpd.halfCarry;
		end
		if (flagUpd.signedEn) begin
			status_d[CRS_POS_SIGNED] = flagUpd.signedRange;
		end
		// writes to the parity bit cannot stick: it always mirrors the operand
		status_d[CRS_POS_PARITY] = ^mainOp_d;
	end

	// stack pointer and stack ram request; push beats pop when both arrive
	always_comb begin
		sp_d      = sp_r;
		stkAddr_d = 8'h00;
		stkWr_d   = 1'b0;
		stkRd_d   = 1'b0;
		stkData_d = 8'h00;
		if (sfrWrEn && sfrAddr == CRS_ADDR_STACK_POINTER) begin
			sp_d = sfrWrData;
		end
		if (pushReq) begin
			sp_d      = sp_r + 8'h01;
			stkAddr_d = sp_r + 8'h01;
			stkWr_d   = 1'b1;
			stkData_d = pushData;
		end else if (popReq) begin
			stkAddr_d = sp_r;
			stkRd_d   = 1'b1;
			sp_d      = sp_r - 8'h01;
		end
	end

	// data pointer bytes; load beats increment beats sfr write
	always_comb begin
		ptrLow_d  = ptrLow_r;
		ptrHigh_d = ptrHigh_r;
		if (sfrWrEn && sfrAddr == CRS_ADDR_POINTER_LOW) begin
			ptrLow_d = sfrWrData;
		end
		if (sfrWrEn && sfrAddr == CRS_ADDR_POINTER_HIGH) begin
			ptrHigh_d = sfrWrData;
		end
		if (ptrLoad) begin
			{ptrHigh_d, ptrLow_d} = ptrLoadData;
		end else if (ptrInc) begin
			{ptrHigh_d, ptrLow_d} = {ptrHigh_r, ptrLow_r} + 16'h0001;
		end
	end

	// sfr read decode; the page register plays no part so every page sees these
	always_comb begin
		rdData_d = 8'h00;
		rdHit_d  = 1'b0;
		if (sfrRdEn) begin
			rdHit_d = 1'b1;
			case (sfrAddr)
				CRS_ADDR_STACK_POINTER: rdData_d = sp_r;
				CRS_ADDR_POINTER_LOW:   rdData_d = ptrLow_r;
				CRS_ADDR_POINTER_HIGH:  rdData_d = ptrHigh_r;
				CRS_ADDR_STATUS_WORD:   rdData_d = status_r;
				CRS_ADDR_MAIN_OPERAND:  rdData_d = mainOp_r;
				CRS_ADDR_AUX_OPERAND:   rdData_d = auxOp_r;
				default: begin
					rdData_d = 8'h00;
					rdHit_d  = 1'b0;
				end
			endcase
		end
	end

	// register file flops
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mainOp_r  <= CRS_RST_MAIN_OPERAND;
			auxOp_r   <= CRS_RST_AUX_OPERAND;
			status_r  <= CRS_RST_STATUS_WORD;
			sp_r      <= CRS_RST_STACK_POINTER;
			ptrLow_r  <= CRS_RST_POINTER_LOW;
			ptrHigh_r <= CRS_RST_POINTER_HIGH;
		end else begin
			mainOp_r  <= mainOp_d;
			auxOp_r   <= auxOp_d;
			status_r  <= status_d;
			sp_r      <= sp_d;
			ptrLow_r  <= ptrLow_d;
			ptrHigh_r <= ptrHigh_d;
		end
	end

	// stack request and read port flops
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stackRamAddr_q <= 8'h00;
			stackRamWr_q   <= 1'b0;
			stackRamRd_q   <= 1'b0;
			stackRamData_q <= 8'h00;
			sfrRdData_q    <= 8'h00;
			sfrRdHit_q     <= 1'b0;
		end else begin
			stackRamAddr_q <= stkAddr_d;
			stackRamWr_q   <= stkWr_d;
			stackRamRd_q   <= stkRd_d;
			stackRamData_q <= stkData_d;
			sfrRdData_q    <= rdData_d;
			sfrRdHit_q     <= rdHit_d;
		end
	end

	// operand address resolution against the current bank and pointers
	crs_addr_unit u_addr (
		.req         (addrReq),
		.bankSel     (status_r[CRS_POS_BANK_HIGH:CRS_POS_BANK_LOW]),
		.stackPtr    (sp_r),
		.dataPtr     ({ptrHigh_r, ptrLow_r}),
		.mainOperand (mainOp_r),
		.effAddr     (calcAddr),
		.effSpace    (calcSpace),
		.regAddr     (calcReg)
	);

	// resolved address is held until the next request
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			effValid_q <= 1'b0;
			effAddr_q  <= 16'h0000;
			effSpace_q <= SPACE_NONE;
			regAddr_q  <= 8'h00;
		end else begin
			effValid_q <= addrReqValid;
			if (addrReqValid) begin
				effAddr_q  <= calcAddr;
				effSpace_q <= calcSpace;
				regAddr_q  <= calcReg;
			end
		end
	end

	// instruction timer counts plain clocks; lengths outside 1..7 are clamped
	always_comb begin
		tmrState_d = tmrState_q;
		tmrCount_d = tmrCount_q;
		done_d     = 1'b0;
		case (tmrState_q)
			TMR_IDLE: begin
				if (instrStart) begin
					tmrState_d = TMR_RUN;
					tmrCount_d = (instrCycles < CRS_INSTR_MIN_CYCLES) ?
						CRS_INSTR_MIN_CYCLES : instrCycles;
				end
			end
			TMR_RUN: begin
				if (tmrCount_q == CRS_INSTR_MIN_CYCLES) begin
					tmrState_d = TMR_IDLE;
					tmrCount_d = 3'h0;
					done_d     = 1'b1;
				end else begin
					tmrCount_d = tmrCount_q - 3'h1;
				end
			end
			default: begin
				tmrState_d = TMR_IDLE;
				tmrCount_d = 3'h0;
			end
		endcase
	end

	// timer flops; a start while busy is ignored
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tmrState_q  <= TMR_IDLE;
			tmrCount_q  <= 3'h0;
			instrDone_q <= 1'b0;
			instrBusy_q <= 1'b0;
		end else begin
			tmrState_q  <= tmrState_d;
			tmrCount_q  <= tmrCount_d;
			instrDone_q <= done_d;
			instrBusy_q <= (tmrState_d == TMR_RUN);
		end
	end

	// visible register state comes straight from the register flops
	assign mainOperand_q  = mainOp_r;
	assign auxOperand_q   = auxOp_r;
	assign statusWord_q   = status_r;
	assign stackPointer_q = sp_r;
	assign dataPointer_q  = {ptrHigh_r, ptrLow_r};

endmodule : crs_core_regs

// ===== rtl/crs_pkg.sv
package crs_pkg;

	// special function addresses of the core registers
	localparam logic [7:0] CRS_ADDR_STACK_POINTER = 8'h81;
	localparam logic [7:0] CRS_ADDR_POINTER_LOW   = 8'h82;
	localparam logic [7:0] CRS_ADDR_POINTER_HIGH  = 8'h83;
	localparam logic [7:0] CRS_ADDR_STATUS_WORD   = 8'hd0;
	localparam logic [7:0] CRS_ADDR_MAIN_OPERAND  = 8'he0;
	localparam logic [7:0] CRS_ADDR_AUX_OPERAND   = 8'hf0;

	// reset values
	localparam logic [7:0] CRS_RST_STACK_POINTER = 8'h07;
	localparam logic [7:0] CRS_RST_POINTER_LOW   = 8'h00;
	localparam logic [7:0] CRS_RST_POINTER_HIGH  = 8'h00;
	localparam logic [7:0] CRS_RST_STATUS_WORD   = 8'h00;
	localparam logic [7:0] CRS_RST_MAIN_OPERAND  = 8'h00;
	localparam logic [7:0] CRS_RST_AUX_OPERAND   = 8'h00;

	// status word field positions
	localparam int CRS_POS_CARRY      = 7;
	localparam int CRS_POS_HALF_CARRY = 6;
	localparam int CRS_POS_USER_ZERO  = 5;
	localparam int CRS_POS_BANK_HIGH  = 4;
	localparam int CRS_POS_BANK_LOW   = 3;
	localparam int CRS_POS_SIGNED     = 2;
	localparam int CRS_POS_USER_ONE   = 1;
	localparam int CRS_POS_PARITY     = 0;

	// register banks sit in the lowest bytes of internal ram
	localparam int CRS_BANK_COUNT = 4;
	localparam int CRS_BANK_SIZE  = 8;
	localparam logic [7:0] CRS_SFR_BOUNDARY = 8'h80;

	// instruction length limits, in core clock cycles
	localparam logic [2:0] CRS_INSTR_MIN_CYCLES = 3'h1;
	localparam logic [2:0] CRS_INSTR_MAX_CYCLES = 3'h7;

	typedef enum logic [9:0] {
		MODE_DIRECT    = 10'h001,
		MODE_IND_RI    = 10'h002,
		MODE_IND_RI_X  = 10'h004,
		MODE_IND_SP    = 10'h008,
		MODE_IND_DATA_POINTER  = 10'h010,
		MODE_REGISTER  = 10'h020,
		MODE_IDX_DATA_POINTER  = 10'h040,
		MODE_IDX_PC    = 10'h080,
		MODE_JMP_IDX   = 10'h100,
		MODE_IMMEDIATE = 10'h200
	} crs_mode_t;

	typedef enum logic [4:0] {
		SPACE_NONE  = 5'h01,
		SPACE_DATA  = 5'h02,
		SPACE_SFR   = 5'h04,
		SPACE_XRAM  = 5'h08,
		SPACE_CODE  = 5'h10
	} crs_space_t;

	typedef enum logic [1:0] {
		TMR_IDLE = 2'h1,
		TMR_RUN  = 2'h2
	} crs_tmr_state_t;

	// flag results from the execution path
	typedef struct packed {
		logic carryEn;
		logic carry;
		logic halfCarryEn;
		logic halfCarry;
		logic signedEn;
		logic signedRange;
	} crs_flag_upd_t;

	// operand address request
	typedef struct packed {
		crs_mode_t   mode;
		logic [2:0]  regSel;
		logic [7:0]  addrField;
		logic [7:0]  riData;
		logic [15:0] pc;
	} crs_addr_req_t;

endpackage : crs_pkg
